//--- dprf_reference_profile_regs.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
// Function
// - Scale bit 7 of priority byte picks threshold unit: 0 ps, 1 ns.
// - Promoted priority bits 5:3 rank the reference while it is in use.
// - Selection priority bits 2:0 rank the reference among all others.
// - Nominal period is 40 bits of femtoseconds, low byte first.
// - Inner tolerance is 20 bits; top nibble in low half of third byte.
// - Outer tolerance is 20 bits laid out like the inner one.
// - Validation timer is 16 bits of milliseconds, low byte first.
// - Redetect timer is 16 bits of milliseconds after the validation timer.
// - Each filter coefficient is a fractional linear part times two to an exponent.
// - Alpha has 16-bit linear, 6-bit, split 3-bit and 4-bit exponents.
// - Beta has 17-bit linear over three bytes and a 5-bit exponent.
// - Gamma has 17-bit linear, bit 16 beside the 5-bit exponent.
// - Delta has 15-bit linear and a 5-bit exponent split over bytes.
// - R and S dividers divide by one more than the programmed value.
// - Fractional divider holds two 10-bit fields packed across three bytes.
// - The profile's phase lock threshold uses the unit chosen by scale.
module dprf_reference_profile_regs (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic refInUse,
  output logic phaseScaleNs,
  output logic [2:0] effPriority,
  output logic [2:0] promotedPriority,
  output logic [2:0] selectPriority,
  output logic [39:0] refPeriodFs,
  output logic [19:0] innerTol,
  output logic [19:0] outerTol,
  output logic [15:0] validationMs,
  output logic [15:0] redetectMs,
  output logic [15:0] alphaLin,
  output logic [5:0] alphaExp1,
  output logic [2:0] alphaExp2,
  output logic [3:0] alphaExp3,
  output logic [16:0] betaLin,
  output logic [4:0] betaExp,
  output logic [16:0] gammaLin,
  output logic [4:0] gammaExp,
  output logic [14:0] deltaLin,
  output logic [4:0] deltaExp,
  output logic [30:0] rDivRatio,
  output logic [20:0] sDivRatio,
  output logic [9:0] uFrac,
  output logic [9:0] vFrac,
  output logic profileValid
);

  dprf_field_if fields ();

  logic [15:0] addrOffset;
  logic profileHit;
  logic [5:0] byteIdx;
  logic wrProfile;
  logic wrCommit;
  logic rdStatus;
  logic pending;
  logic sBelowMin;
  logic orderFault;
  logic [7:0] statusByte;
  logic [7:0] altByte;
  logic [327:0] image;

  // Address decode; the profile bytes sit in one contiguous window.
  assign addrOffset = regAddr - dprf_pkg::DPRF_BASE_ADDR;
  assign profileHit = (regAddr >= dprf_pkg::DPRF_BASE_ADDR) && (regAddr <= dprf_pkg::DPRF_LAST_ADDR);
  assign byteIdx = addrOffset[5:0];
  assign wrProfile = regWr && profileHit;
  assign wrCommit = regWr && (regAddr == dprf_pkg::DPRF_CTRL_ADDR) && regWrData[dprf_pkg::DPRF_CTRL_COMMIT_BIT];
  assign rdStatus = regAddr == dprf_pkg::DPRF_STATUS_ADDR;

  // Programming checks on the staged values; software is expected to keep them clear.
  assign sBelowMin = fields.sDiv < dprf_pkg::DPRF_S_MIN;
  assign orderFault = fields.promoted > fields.select;

  // Status byte; unmapped addresses and the commit byte read as zero.
  always_comb begin
    statusByte = 8'h00;
    statusByte[dprf_pkg::DPRF_STAT_PENDING_BIT] = pending;
    statusByte[dprf_pkg::DPRF_STAT_SMIN_BIT] = sBelowMin;
    statusByte[dprf_pkg::DPRF_STAT_ORDER_BIT] = orderFault;
    statusByte[dprf_pkg::DPRF_STAT_VALID_BIT] = profileValid;
    altByte = rdStatus ? statusByte : 8'h00;
  end

  // Staging bytes with masked writes and a registered read port.
  dprf_byte_store u_store (
    .mclk(mclk),
    .srst(srst),
    .wrEn(wrProfile),
    .wrIdx(byteIdx),
    .wrData(regWrData),
    .rdEn(regRd),
    .rdHit(profileHit),
    .rdIdx(byteIdx),
    .rdAlt(altByte),
    .rdData(regRdData),
    .image(image)
  );

  // Byte image to named fields.
  dprf_field_unpack u_unpack (
    .image(image),
    .f(fields)
  );

  // Pending marks staged edits not yet committed; a write in the commit cycle keeps it set.
  always_ff @(posedge mclk) begin
    if (srst) begin
      pending <= 1'b0;
    end else if (wrProfile) begin
      pending <= 1'b1;
    end else if (wrCommit) begin
      pending <= 1'b0;
    end
  end

  // Profile counts as valid once any commit has happened.
  always_ff @(posedge mclk) begin
    if (srst) begin
      profileValid <= 1'b0;
    end else if (wrCommit) begin
      profileValid <= 1'b1;
    end
  end

  // Priorities and scale move to the loop together at commit.
  always_ff @(posedge mclk) begin
    if (srst) begin
      phaseScaleNs <= 1'b0;
      promotedPriority <= 3'h0;
      selectPriority <= 3'h0;
    end else if (wrCommit) begin
      phaseScaleNs <= fields.scale;
      promotedPriority <= fields.promoted;
      selectPriority <= fields.select;
    end
  end

  // Rank in force: promoted while this reference is the one in use.
  always_ff @(posedge mclk) begin
    if (srst) begin
      effPriority <= 3'h0;
    end else begin
      effPriority <= refInUse ? promotedPriority : selectPriority;
    end
  end

  // Period, tolerances and timers, applied whole so no half-written word reaches the loop.
  always_ff @(posedge mclk) begin
    if (srst) begin
      refPeriodFs <= 40'h0000000000;
      innerTol <= 20'h00000;
      outerTol <= 20'h00000;
      validationMs <= 16'h0000;
      redetectMs <= 16'h0000;
    end else if (wrCommit) begin
      refPeriodFs <= fields.period;
      innerTol <= fields.innerTol;
      outerTol <= fields.outerTol;
      validationMs <= fields.valTimer;
      redetectMs <= fields.redetTimer;
    end
  end

  // Loop filter parts; the loop forms linear times two to the exponent from these.
  always_ff @(posedge mclk) begin
    if (srst) begin
      alphaLin <= 16'h0000;
      alphaExp1 <= 6'h00;
      alphaExp2 <= 3'h0;
      alphaExp3 <= 4'h0;
      betaLin <= 17'h00000;
      betaExp <= 5'h00;
      gammaLin <= 17'h00000;
      gammaExp <= 5'h00;
      deltaLin <= 15'h0000;
      deltaExp <= 5'h00;
    end else if (wrCommit) begin
      alphaLin <= fields.alpha0;
      alphaExp1 <= fields.alpha1;
      alphaExp2 <= fields.alpha2;
      alphaExp3 <= fields.alpha3;
      betaLin <= fields.beta0;
      betaExp <= fields.beta1;
      gammaLin <= fields.gamma0;
      gammaExp <= fields.gamma1;
      deltaLin <= fields.delta0;
      deltaExp <= fields.delta1;
    end
  end

  // R and S dividers leave as actual ratios, one wider so the largest value does not wrap; U and V pass as staged.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rDivRatio <= 31'h00000000;
      sDivRatio <= 21'h000000;
      uFrac <= 10'h000;
      vFrac <= 10'h000;
    end else if (wrCommit) begin
      rDivRatio <= {1'b0, fields.rDiv} + 31'h00000001;
      sDivRatio <= {1'b0, fields.sDiv} + 21'h000001;
      uFrac <= fields.uDiv;
      vFrac <= fields.vDiv;
    end
  end

  // Checks on the applied state.
  scale_commit_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> phaseScaleNs == $past(fields.scale))
    else $error("scale bit not applied at commit");

  eff_priority_a: assert property (@(posedge mclk) disable iff (srst)
    refInUse ##1 refInUse |-> effPriority == $past(promotedPriority))
    else $error("promoted priority not in force while reference in use");

  select_priority_a: assert property (@(posedge mclk) disable iff (srst)
    !refInUse |=> effPriority == $past(selectPriority))
    else $error("selection priority not in force while idle");

  period_whole_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> refPeriodFs == {$past(image[47:40]), $past(image[39:8])})
    else $error("reference period byte order wrong");

  inner_tol_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> innerTol == {$past(image[83:80]), $past(image[79:64])})
    else $error("inner tolerance packing wrong");

  r_ratio_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> rDivRatio == {1'b0, $past(fields.rDiv)} + 31'h00000001)
    else $error("input divider ratio is not value plus one");

  s_ratio_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> sDivRatio == {1'b0, $past(fields.sDiv)} + 21'h000001)
    else $error("feedback divider ratio is not value plus one");

  hold_applied_a: assert property (@(posedge mclk) disable iff (srst)
    !wrCommit |=> $stable(rDivRatio) && $stable(refPeriodFs) && $stable(betaLin))
    else $error("applied field changed without commit");

  pending_set_a: assert property (@(posedge mclk) disable iff (srst)
    wrProfile |=> pending ##1 (pending || $past(wrCommit)))
    else $error("pending flag lost after profile write");

  status_read_a: assert property (@(posedge mclk) disable iff (srst)
    regRd && rdStatus |=> regRdData[dprf_pkg::DPRF_STAT_SMIN_BIT] == $past(sBelowMin))
    else $error("divider minimum flag misreported");

  // The packing checks below rebuild each field from raw image bits, not from the unpacker.
  priority_fields_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> promotedPriority == $past(image[5:3]) && selectPriority == $past(image[2:0]))
    else $error("priority fields not applied at commit");

  // Outer tolerance mirrors the inner layout three bytes higher.
  outer_tol_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> outerTol == {$past(image[107:104]), $past(image[103:88])})
    else $error("outer tolerance packing wrong");

  // Both timers are plain words, low byte first.
  val_timer_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> validationMs == $past(image[127:112]))
    else $error("validation timer byte order wrong");

  // A swapped pair of timer bytes would only show with unequal bytes, which the tests write.
  redetect_timer_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> redetectMs == $past(image[143:128]))
    else $error("redetect timer byte order wrong");

  // Alpha's second exponent straddles two bytes, so a slip by one bit shows here first.
  alpha_parts_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> alphaLin == $past(image[159:144]) && alphaExp1 == $past(image[165:160])
      && alphaExp2 == $past(image[168:166]) && alphaExp3 == $past(image[239:236]))
    else $error("alpha coefficient parts misplaced");

  // Beta and delta parts stay contiguous in the image although they cross byte borders.
  beta_parts_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> betaLin == $past(image[185:169]) && betaExp == $past(image[190:186]))
    else $error("beta coefficient parts misplaced");

  // Gamma keeps its top linear bit just below its exponent in the shared byte.
  gamma_parts_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> gammaLin == $past(image[208:192]) && gammaExp == $past(image[213:209]))
    else $error("gamma coefficient parts misplaced");

  // Delta's exponent starts in the top bit of one byte and ends in the next.
  delta_parts_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> deltaLin == $past(image[230:216]) && deltaExp == $past(image[235:231]))
    else $error("delta coefficient parts misplaced");

  // The two fractional fields share the middle byte; each must take only its own bits.
  frac_parts_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> vFrac == $past(image[313:304]) && uFrac == $past(image[325:316]))
    else $error("fractional divider fields misplaced");

  // Filter and tolerance outputs must hold between commits too, or a half-written word leaks.
  hold_filter_a: assert property (@(posedge mclk) disable iff (srst)
    !wrCommit |=> $stable(innerTol) && $stable(alphaLin) && $stable(deltaExp)
      && $stable(uFrac) && $stable(promotedPriority))
    else $error("applied filter or tolerance changed without commit");

  // Commit clears the pending flag; a profile write cannot share its cycle.
  pending_clear_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> !pending)
    else $error("pending flag not cleared by commit");

  // Valid is sticky from the first commit until the next reset.
  valid_commit_a: assert property (@(posedge mclk) disable iff (srst)
    wrCommit |=> profileValid)
    else $error("profile not marked valid after commit");

  // The order and low-S flags are recomputed from the staged image rather than from the flag logic.
  order_flag_a: assert property (@(posedge mclk) disable iff (srst)
    regRd && rdStatus |=> regRdData[dprf_pkg::DPRF_STAT_ORDER_BIT] == ($past(image[5:3]) > $past(image[2:0])))
    else $error("priority order flag misreported");

  // A low S is only flagged, never corrected, so software must read the flag itself.
  smin_flag_a: assert property (@(posedge mclk) disable iff (srst)
    regRd && rdStatus |=> regRdData[dprf_pkg::DPRF_STAT_SMIN_BIT]
      == ({$past(image[291:288]), $past(image[287:272])} < dprf_pkg::DPRF_S_MIN))
    else $error("divider minimum flag disagrees with staged value");

  // The valid bit in the status byte tracks the applied state, not the staged one.
  valid_flag_a: assert property (@(posedge mclk) disable iff (srst)
    regRd && rdStatus |=> regRdData[dprf_pkg::DPRF_STAT_VALID_BIT] == $past(profileValid))
    else $error("valid flag misreported in status");

  // The priority byte's unused bit, the pad bytes and the high nibbles of both tolerance third bytes must never store a one, whatever software writes.
  pad_unused_a: assert property (@(posedge mclk) disable iff (srst)
    image[6] == 1'b0 && image[63:48] == 16'h0000 && image[87:84] == 4'h0 && image[111:108] == 4'h0)
    else $error("unused profile bit holds a one");

  // Main scenarios: a full commit, a switch, a status poll, a scale change and a late reset.
  commit_c: cover property (@(posedge mclk) disable iff (srst) wrProfile ##[1:20] wrCommit);
  switch_c: cover property (@(posedge mclk) disable iff (srst) profileValid && $rose(refInUse));
  status_c: cover property (@(posedge mclk) disable iff (srst) regRd && rdStatus && pending);
  scale_ns_c: cover property (@(posedge mclk) disable iff (srst) wrCommit ##1 phaseScaleNs);
  reset_mid_c: cover property (@(posedge mclk) profileValid ##1 srst);

endmodule : dprf_reference_profile_regs

//--- dprf_pkg.sv
package dprf_pkg;

  // Address window of the profile bytes and of the two commit/status bytes.
  localparam logic [15:0] DPRF_BASE_ADDR = 16'h06B2;
  localparam int DPRF_NUM_BYTES = 41;
  localparam logic [15:0] DPRF_LAST_ADDR = 16'h06DA;
  localparam logic [15:0] DPRF_CTRL_ADDR = 16'h06FE;
  localparam logic [15:0] DPRF_STATUS_ADDR = 16'h06FF;

  // Printed register offsets, kept for software and for the tests.
  localparam logic [15:0] DPRF_PRIORITY_CTRL_ADDR = 16'h06B2;
  localparam logic [15:0] DPRF_NOMINAL_REF_PERIOD_ADDR = 16'h06B3;
  localparam logic [15:0] DPRF_PERIOD_PAD_ADDR = 16'h06B8;
  localparam logic [15:0] DPRF_INNER_TOL_ADDR = 16'h06BA;
  localparam logic [15:0] DPRF_OUTER_TOL_ADDR = 16'h06BD;
  localparam logic [15:0] DPRF_VALIDATION_TIMER_ADDR = 16'h06C0;
  localparam logic [15:0] DPRF_REDETECT_TIMER_ADDR = 16'h06C2;
  localparam logic [15:0] DPRF_LOOP_FILTER_ADDR = 16'h06C4;
  localparam logic [15:0] DPRF_INPUT_REF_DIV_ADDR = 16'h06D0;
  localparam logic [15:0] DPRF_INTEGER_FB_DIV_ADDR = 16'h06D4;
  localparam logic [15:0] DPRF_FRACTIONAL_FB_DIV_ADDR = 16'h06D8;

  // Bit positions in the commit and status bytes.
  localparam int DPRF_CTRL_COMMIT_BIT = 0;
  localparam int DPRF_STAT_PENDING_BIT = 0;
  localparam int DPRF_STAT_SMIN_BIT = 1;
  localparam int DPRF_STAT_ORDER_BIT = 2;
  localparam int DPRF_STAT_VALID_BIT = 3;

  // Values after reset and limits.
  localparam logic [7:0] DPRF_BYTE_RESET = 8'h00;
  localparam logic [19:0] DPRF_S_MIN = 20'h00007;

  // Writable bits of each profile byte; unused bits store and read as zero.
  function automatic logic [7:0] byte_mask(input logic [5:0] idx);
    logic [7:0] m;
    m = 8'hFF;
    case (idx)
      6'h00: m = 8'hBF;
      6'h06, 6'h07: m = 8'h00;
      6'h0A, 6'h0D: m = 8'h0F;
      6'h17: m = 8'h7F;
      6'h1A: m = 8'h3F;
      6'h21: m = 8'h3F;
      6'h24: m = 8'h0F;
      6'h25: m = 8'h00;
      6'h27: m = 8'hF3;
      6'h28: m = 8'h3F;
      default: m = 8'hFF;
    endcase
    return m;
  endfunction : byte_mask

endpackage : dprf_pkg

//--- dprf_field_if.sv
`timescale 1ns/1ps
// Decoded profile fields passed from the unpacker to the top.
interface dprf_field_if;
  logic scale;
  logic [2:0] promoted;
  logic [2:0] select;
  logic [39:0] period;
  logic [19:0] innerTol;
  logic [19:0] outerTol;
  logic [15:0] valTimer;
  logic [15:0] redetTimer;
  logic [15:0] alpha0;
  logic [5:0] alpha1;
  logic [2:0] alpha2;
  logic [3:0] alpha3;
  logic [16:0] beta0;
  logic [4:0] beta1;
  logic [16:0] gamma0;
  logic [4:0] gamma1;
  logic [14:0] delta0;
  logic [4:0] delta1;
  logic [29:0] rDiv;
  logic [19:0] sDiv;
  logic [9:0] uDiv;
  logic [9:0] vDiv;
  modport src (output scale, promoted, select, period, innerTol, outerTol, valTimer, redetTimer, alpha0, alpha1,
    alpha2, alpha3, beta0, beta1, gamma0, gamma1, delta0, delta1, rDiv, sDiv, uDiv, vDiv);
  modport dst (input scale, promoted, select, period, innerTol, outerTol, valTimer, redetTimer, alpha0, alpha1,
    alpha2, alpha3, beta0, beta1, gamma0, gamma1, delta0, delta1, rDiv, sDiv, uDiv, vDiv);
endinterface : dprf_field_if

//--- dprf_byte_store.sv
`timescale 1ns/1ps
module dprf_byte_store (
  input wire logic mclk,
  input wire logic srst,
  input wire logic wrEn,
  input wire logic [5:0] wrIdx,
  input wire logic [7:0] wrData,
  input wire logic rdEn,
  input wire logic rdHit,
  input wire logic [5:0] rdIdx,
  input wire logic [7:0] rdAlt,
  output logic [7:0] rdData,
  output logic [327:0] image
);

  logic [7:0] mem [0:dprf_pkg::DPRF_NUM_BYTES-1];

  // Byte writes are masked so unused bits never hold a one.
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < dprf_pkg::DPRF_NUM_BYTES; i++) begin
        mem[i] <= dprf_pkg::DPRF_BYTE_RESET;
      end
    end else if (wrEn) begin
      mem[wrIdx] <= wrData & dprf_pkg::byte_mask(wrIdx);
    end
  end

  // Registered read port; the top's own bytes enter through rdAlt.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdData <= 8'h00;
    end else if (rdEn) begin
      rdData <= rdHit ? mem[rdIdx] : rdAlt;
    end else begin
      rdData <= 8'h00;
    end
  end

  // Whole staging image for the field unpacker.
  for (genvar g = 0; g < dprf_pkg::DPRF_NUM_BYTES; g++) begin : g_img
    assign image[8*g +: 8] = mem[g];
  end

endmodule : dprf_byte_store

//--- dprf_field_unpack.sv
`timescale 1ns/1ps
module dprf_field_unpack (
  input wire logic [327:0] image,
  dprf_field_if.src f
);

  logic [7:0] b [0:40];

  for (genvar g = 0; g < 41; g++) begin : g_b
    assign b[g] = image[8*g +: 8];
  end

  // Priority byte and period, low byte at the lowest address.
  assign f.scale = b[0][7];
  assign f.promoted = b[0][5:3];
  assign f.select = b[0][2:0];
  assign f.period = {b[5], b[4], b[3], b[2], b[1]};
  // Tolerances carry their top nibble in the low half of the third byte.
  assign f.innerTol = {b[10][3:0], b[9], b[8]};
  assign f.outerTol = {b[13][3:0], b[12], b[11]};
  assign f.valTimer = {b[15], b[14]};
  assign f.redetTimer = {b[17], b[16]};
  // Loop filter parts are spread across byte borders.
  assign f.alpha0 = {b[19], b[18]};
  assign f.alpha1 = b[20][5:0];
  assign f.alpha2 = {b[21][0], b[20][7:6]};
  assign f.beta0 = {b[23][1:0], b[22], b[21][7:1]};
  assign f.beta1 = b[23][6:2];
  assign f.gamma0 = {b[26][0], b[25], b[24]};
  assign f.gamma1 = b[26][5:1];
  assign f.delta0 = {b[28][6:0], b[27]};
  assign f.delta1 = {b[29][3:0], b[28][7]};
  assign f.alpha3 = b[29][7:4];
  // Dividers.
  assign f.rDiv = {b[33][5:0], b[32], b[31], b[30]};
  assign f.sDiv = {b[36][3:0], b[35], b[34]};
  assign f.vDiv = {b[39][1:0], b[38]};
  assign f.uDiv = {b[40][5:0], b[39][7:4]};

endmodule : dprf_field_unpack

//--- dprf_reference_profile_regs_tb_top.sv
`timescale 1ns/1ps
module dprf_reference_profile_regs_tb_top;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic refInUse = 1'b0;
  logic [7:0] regRdData;
  logic phaseScaleNs, profileValid;
  logic [2:0] effPriority, promotedPriority, selectPriority, alphaExp2;
  logic [39:0] refPeriodFs;
  logic [19:0] innerTol, outerTol;
  logic [15:0] validationMs, redetectMs, alphaLin;
  logic [5:0] alphaExp1;
  logic [3:0] alphaExp3;
  logic [16:0] betaLin, gammaLin;
  logic [4:0] betaExp, gammaExp, deltaExp;
  logic [14:0] deltaLin;
  logic [30:0] rDivRatio;
  logic [20:0] sDivRatio;
  logic [9:0] uFrac, vFrac;
  int errorCnt = 0;
  int nTests = 0;
  logic [7:0] pb [41];
  logic [7:0] ex [41];
  logic [7:0] d;

  // Free-running 25 MHz system clock.
  always #20 mclk = ~mclk;

  dprf_reference_profile_regs dut (.mclk(mclk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .refInUse(refInUse), .phaseScaleNs(phaseScaleNs),
    .effPriority(effPriority), .promotedPriority(promotedPriority), .selectPriority(selectPriority),
    .refPeriodFs(refPeriodFs), .innerTol(innerTol), .outerTol(outerTol), .validationMs(validationMs),
    .redetectMs(redetectMs), .alphaLin(alphaLin), .alphaExp1(alphaExp1), .alphaExp2(alphaExp2),
    .alphaExp3(alphaExp3), .betaLin(betaLin), .betaExp(betaExp), .gammaLin(gammaLin), .gammaExp(gammaExp),
    .deltaLin(deltaLin), .deltaExp(deltaExp), .rDivRatio(rDivRatio), .sDivRatio(sDivRatio), .uFrac(uFrac),
    .vFrac(vFrac), .profileValid(profileValid));

  task automatic final_report();
    $display("Checks made: %0d, mismatches: %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // A write leaves its strobe up so that writes can follow with no gap; idle or rd drops it.
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    regWr <= 1'b1;
    regRd <= 1'b0;
    regAddr <= a;
    regWrData <= v;
    @(posedge mclk);
  endtask : wr

  // Read data is taken at the second edge, before that edge's own updates land.
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    regWr <= 1'b0;
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
    v = regRdData;
  endtask : rd

  task automatic rdchk(input string name, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(name, exp, v);
  endtask : rdchk

  task automatic idle(input int n);
    regWr <= 1'b0;
    regRd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask : idle

  // Bits that hold data in each profile byte; the rest must store nothing.
  function automatic logic [7:0] usedBits(input int i);
    case (i)
      0: return 8'hBF;
      6, 7, 37: return 8'h00;
      10, 13, 36: return 8'h0F;
      23: return 8'h7F;
      26, 33, 40: return 8'h3F;
      39: return 8'hF3;
      default: return 8'hFF;
    endcase
  endfunction : usedBits

  // Every applied field is rebuilt from the expected byte image by the documented packing.
  task automatic checkApplied();
    chk("phaseScaleNs", ex[0][7], phaseScaleNs);
    chk("promotedPriority", ex[0][5:3], promotedPriority);
    chk("selectPriority", ex[0][2:0], selectPriority);
    chk("refPeriodFs", {ex[5], ex[4], ex[3], ex[2], ex[1]}, refPeriodFs);
    chk("innerTol", {ex[10][3:0], ex[9], ex[8]}, innerTol);
    chk("outerTol", {ex[13][3:0], ex[12], ex[11]}, outerTol);
    chk("validationMs", {ex[15], ex[14]}, validationMs);
    chk("redetectMs", {ex[17], ex[16]}, redetectMs);
    chk("alphaLin", {ex[19], ex[18]}, alphaLin);
    chk("alphaExp1", ex[20][5:0], alphaExp1);
    chk("alphaExp2", {ex[21][0], ex[20][7:6]}, alphaExp2);
    chk("alphaExp3", ex[29][7:4], alphaExp3);
    chk("betaLin", {ex[23][1:0], ex[22], ex[21][7:1]}, betaLin);
    chk("betaExp", ex[23][6:2], betaExp);
    chk("gammaLin", {ex[26][0], ex[25], ex[24]}, gammaLin);
    chk("gammaExp", ex[26][5:1], gammaExp);
    chk("deltaLin", {ex[28][6:0], ex[27]}, deltaLin);
    chk("deltaExp", {ex[29][3:0], ex[28][7]}, deltaExp);
    chk("rDivRatio", {ex[33][5:0], ex[32], ex[31], ex[30]} + 31'h00000001, rDivRatio);
    chk("sDivRatio", {ex[36][3:0], ex[35], ex[34]} + 21'h000001, sDivRatio);
    chk("vFrac", {ex[39][1:0], ex[38]}, vFrac);
    chk("uFrac", {ex[40][5:0], ex[39][7:4]}, uFrac);
    chk("profileValid", 1, profileValid);
  endtask : checkApplied

  // Hang guard; the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge mclk);
    errorCnt++;
    $display("[FAIL] watchdog expected done seen timeout");
    final_report();
  end

  // Main sequence.
  initial begin
    for (int i = 0; i < 41; i++) begin
      pb[i] = 8'(i * 8'h37 + 8'h5A);
    end
    pb[0] = 8'hD3;
    pb[6] = 8'h00;
    pb[7] = 8'h00;
    for (int i = 0; i < 41; i++) begin
      ex[i] = pb[i] & usedBits(i);
    end
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    chk("validAtReset", 0, profileValid);
    chk("sRatioAtReset", 0, sDivRatio);
    // Whole profile written back to back, then read back one byte every second cycle.
    for (int i = 0; i < 41; i++) begin
      wr(dprf_pkg::DPRF_BASE_ADDR + 16'(i), pb[i]);
    end
    for (int i = 0; i < 41; i++) begin
      rdchk("stagedByte", dprf_pkg::DPRF_BASE_ADDR + 16'(i), ex[i]);
    end
    idle(1);
    chk("readDataIdle", 0, regRdData);
    chk("periodBeforeCommit", 0, refPeriodFs);
    chk("validBeforeCommit", 0, profileValid);
    rdchk("statusStaged", dprf_pkg::DPRF_STATUS_ADDR, 8'h01);
    wr(dprf_pkg::DPRF_CTRL_ADDR, 8'hFE);
    rdchk("statusNoCommit", dprf_pkg::DPRF_STATUS_ADDR, 8'h01);
    wr(dprf_pkg::DPRF_CTRL_ADDR, 8'h01);
    idle(1);
    checkApplied();
    rdchk("statusCommitted", dprf_pkg::DPRF_STATUS_ADDR, 8'h08);
    rdchk("commitReadsZero", dprf_pkg::DPRF_CTRL_ADDR, 8'h00);
    chk("effSelect", ex[0][2:0], effPriority);
    refInUse <= 1'b1;
    idle(2);
    chk("effPromoted", ex[0][5:3], effPriority);
    refInUse <= 1'b0;
    idle(2);
    chk("effBack", ex[0][2:0], effPriority);
    // Pad, status and unmapped places take no data.
    wr(dprf_pkg::DPRF_PERIOD_PAD_ADDR, 8'h55);
    wr(16'h06E4, 8'hAA);
    wr(dprf_pkg::DPRF_STATUS_ADDR, 8'hFF);
    rdchk("padByte", dprf_pkg::DPRF_PERIOD_PAD_ADDR, 8'h00);
    rdchk("unmapped", 16'h06E4, 8'h00);
    // Partial edits must not reach the outputs; status flags a low S and a bad priority order.
    wr(dprf_pkg::DPRF_INTEGER_FB_DIV_ADDR, 8'h03);
    wr(dprf_pkg::DPRF_INTEGER_FB_DIV_ADDR + 16'h0001, 8'h00);
    wr(dprf_pkg::DPRF_INTEGER_FB_DIV_ADDR + 16'h0002, 8'h00);
    wr(dprf_pkg::DPRF_PRIORITY_CTRL_ADDR, 8'h3B);
    rdchk("statusFlags", dprf_pkg::DPRF_STATUS_ADDR, 8'h0F);
    chk("sHeld", {ex[36][3:0], ex[35], ex[34]} + 21'h000001, sDivRatio);
    chk("promotedHeld", ex[0][5:3], promotedPriority);
    // Smallest legal S and a new period top byte, applied at the next commit.
    ex[34] = 8'h07;
    ex[35] = 8'h00;
    ex[36] = 8'h00;
    ex[5] = 8'hC3;
    wr(dprf_pkg::DPRF_INTEGER_FB_DIV_ADDR, 8'h07);
    wr(dprf_pkg::DPRF_PRIORITY_CTRL_ADDR, pb[0]);
    wr(dprf_pkg::DPRF_NOMINAL_REF_PERIOD_ADDR + 16'h0004, 8'hC3);
    wr(dprf_pkg::DPRF_CTRL_ADDR, 8'h01);
    idle(1);
    checkApplied();
    rdchk("statusClean", dprf_pkg::DPRF_STATUS_ADDR, 8'h08);
    // A second reset in mid-run clears staged and applied state alike.
    srst <= 1'b1;
    idle(2);
    srst <= 1'b0;
    idle(1);
    chk("validAfterReset", 0, profileValid);
    chk("rRatioAfterReset", 0, rDivRatio);
    rdchk("prioAfterReset", dprf_pkg::DPRF_PRIORITY_CTRL_ADDR, 8'h00);
    final_report();
  end
endmodule : dprf_reference_profile_regs_tb_top
